// ==== pkg/boot_guard_pkg.sv ====
// package for the boot flash access guard
// assumes a word-addressed program flash split into application and boot sections
package boot_guard_pkg;

  // ----------------------------------------------------------------
  // flash geometry
  // ----------------------------------------------------------------
  localparam int unsigned WORD_ADDR_BITS = 15;
  localparam int unsigned PAGE_WORD_BITS = 6;
  localparam int unsigned PAGE_NUM_BITS = WORD_ADDR_BITS - PAGE_WORD_BITS;

  // first word of the boot loader section, also the boot reset vector
  localparam logic [14:0] BOOT_START_WORD = 15'h3800;
  // first word of the no-read-while-write section
  localparam logic [14:0] NO_READ_WHILE_WRITE_SECTION_START_WORD = 15'h3800;
  // application reset vector
  localparam logic [14:0] APP_RESET_WORD = 15'h0000;

  // ----------------------------------------------------------------
  // protection field encodings (1 = unprogrammed, 0 = programmed)
  // ----------------------------------------------------------------
  localparam logic [1:0] PROT_FIELD_ERASED = 2'h3;
  localparam logic [1:0] PROT_RESET = 2'h3;

  // positions of the protection bits in the lock data byte
  localparam int unsigned LOCK_APP_LO_POS = 2;
  localparam int unsigned LOCK_APP_HI_POS = 3;
  localparam int unsigned LOCK_BOOT_LO_POS = 4;
  localparam int unsigned LOCK_BOOT_HI_POS = 5;

  // value returned by a refused load
  localparam logic [7:0] BLOCKED_READ_BYTE = 8'hFF;
  localparam logic [7:0] LOAD_DATA_RESET = 8'h00;

  // ----------------------------------------------------------------
  // store instruction operations
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    STORE_FILL = 2'h0,
    STORE_ERASE = 2'h1,
    STORE_WRITE = 2'h2,
    STORE_LOCK_SET = 2'h3
  } store_op_t;

  // programming engine states
  typedef enum logic [1:0]
  {
    ENG_IDLE,
    ENG_RWW_BUSY,
    ENG_NO_READ_WHILE_WRITE_SECTION_BUSY
  } engine_state_t;

endpackage : boot_guard_pkg

// ==== verilog/boot_flash_access_guard.sv ====
// boot flash access guard: section protection, read-while-write control,
// reset vector selection and pointer splitting for self-programming.
// assumes a flash macro on the same clock with a one-cycle start pulse and a
// done pulse, combinational word read, and a core that holds requests one cycle.
//
// Summary of operation
// - programming the rww section never stalls the core; no_read_while_write_section stays readable
// - programming the no_read_while_write_section section stalls the core until the operation ends
// - separate application and boot protection fields, set independently
// - protection bits only get programmed; chip erase restores ones, reset reloads the nonvolatile levels
// - the general write lock does not gate store-instruction programming
// - the general read/write lock does not gate loads or stores
// - protection bit one means unprogrammed, zero means programmed
// - application field 10 or 00 blocks stores into the application section
// - application field 00 or 01 blocks boot-side loads of the application
// - application field 00/01 with boot vectors masks interrupts in application
// - boot field 10 or 00 blocks stores into the boot section
// - boot field 00 or 01 blocks application-side loads of the boot section
// - boot field 00/01 with application vectors masks interrupts in boot
// - reset vector is word zero unprogrammed, boot start when fuse programmed
// - the core has no path to change any fuse
// - target address is the pointer, high byte over low byte
// - low pointer bits index the word in a page, high bits the page
// - target page is latched when a programming operation starts
// - setting protection bits ignores the pointer entirely
// - loads address bytes, pointer bit zero picks low or high byte
// - stores start programming only when executed from the boot section
// - rww busy flag reads one while the rww section is blocked
`timescale 1ns/1ps
`default_nettype none

module boot_flash_access_guard
  import boot_guard_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  // nonvolatile protection and fuse levels, from outside the clock domain
  input wire logic app_protect_bit_hi_in,
  input wire logic app_protect_bit_lo_in,
  input wire logic boot_protect_bit_hi_in,
  input wire logic boot_protect_bit_lo_in,
  input wire logic boot_reset_select_fuse_in,
  // chip erase level from the programming interface
  input wire logic chip_erase_in,
  // core side
  input wire logic [14:0] exec_word_addr_in,
  input wire logic vectors_in_boot_in,
  input wire logic [7:0] pointer_high_byte_in,
  input wire logic [7:0] pointer_low_byte_in,
  input wire logic program_store_instr_in,
  input wire logic [1:0] store_op_in,
  input wire logic [7:0] lock_data_in,
  input wire logic load_req_in,
  input wire logic fetch_req_in,
  input wire logic rww_reenable_in,
  output logic stall_core_out,
  output logic rww_busy_flag_out,
  output logic irq_block_out,
  output logic [14:0] reset_vector_out,
  output logic load_valid_out,
  output logic [7:0] load_data_out,
  output logic fetch_blocked_out,
  output logic [1:0] app_protect_out,
  output logic [1:0] boot_protect_out,
  // flash macro side
  output logic [14:0] flash_read_addr_out,
  input wire logic [15:0] flash_read_data_in,
  output logic flash_erase_start_out,
  output logic flash_write_start_out,
  output logic [8:0] flash_page_out,
  output logic buffer_fill_out,
  output logic [5:0] buffer_word_out,
  input wire logic flash_done_in
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [4:0] nv_meta;
  logic [4:0] nv_sync;
  logic erase_meta;
  logic erase_sync;
  logic erase_seen;
  logic [1:0] capture_count;
  logic capture_now;
  logic [1:0] app_protect;
  logic [1:0] boot_protect;
  logic boot_fuse_programmed;
  engine_state_t state;
  logic rww_busy;
  logic [15:0] pointer;
  logic [14:0] target_word;
  logic [8:0] target_page;
  logic exec_in_boot;
  logic target_in_boot;
  logic target_in_no_read_while_write_section;
  logic store_allowed;
  logic program_req;
  logic store_blocked;
  logic load_blocked;
  logic next_irq_block;

  // ----------------------------------------------------------------
  // synchronisers for nonvolatile levels and chip erase
  // ----------------------------------------------------------------
  // two flops ahead of any logic; first stage feeds only the second
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      nv_meta <= 5'h1F;
      nv_sync <= 5'h1F;
      erase_meta <= 1'b0;
      erase_sync <= 1'b0;
      erase_seen <= 1'b0;
    end
    else
    begin
      nv_meta <= {app_protect_bit_hi_in, app_protect_bit_lo_in, boot_protect_bit_hi_in,
                  boot_protect_bit_lo_in, boot_reset_select_fuse_in};
      nv_sync <= nv_meta;
      erase_meta <= chip_erase_in;
      erase_sync <= erase_meta;
      erase_seen <= erase_sync;
    end
  end

  // ----------------------------------------------------------------
  // capture flag: fields are loaded once after reset release
  // ----------------------------------------------------------------
  // wait two cycles so the synchronised values are settled, then saturate
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      capture_count <= 2'h0;
    end
    else if (capture_count != 2'h3)
    begin
      capture_count <= capture_count + 2'h1;
    end
  end

  assign capture_now = (capture_count == 2'h2); // one capture per reset

  // ----------------------------------------------------------------
  // protection fields
  // ----------------------------------------------------------------
  // bits can only go from one to zero by software; chip erase sets them;
  // the boot fuse is sampled with them and has no core write path
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      app_protect <= PROT_RESET;
      boot_protect <= PROT_RESET;
      boot_fuse_programmed <= 1'b0;
    end
    else if (capture_now)
    begin
      app_protect <= nv_sync[4:3];
      boot_protect <= nv_sync[2:1];
      boot_fuse_programmed <= !nv_sync[0];
    end
    else if (erase_sync && !erase_seen)
    begin
      app_protect <= PROT_FIELD_ERASED;
      boot_protect <= PROT_FIELD_ERASED;
    end
    else if (program_req && store_op_t'(store_op_in) == STORE_LOCK_SET)
    begin
      // pointer is not consulted here
      app_protect <= app_protect & {lock_data_in[LOCK_APP_HI_POS],
                                    lock_data_in[LOCK_APP_LO_POS]};
      boot_protect <= boot_protect & {lock_data_in[LOCK_BOOT_HI_POS],
                                      lock_data_in[LOCK_BOOT_LO_POS]};
    end
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // pointer is a byte address; store targets drop bit zero
  assign pointer = {pointer_high_byte_in, pointer_low_byte_in};
  assign target_word = pointer[15:1];
  assign target_page = target_word[14:PAGE_WORD_BITS];
  assign exec_in_boot = (exec_word_addr_in >= BOOT_START_WORD);
  assign target_in_boot = (target_word >= BOOT_START_WORD);
  assign target_in_no_read_while_write_section = (target_word >= NO_READ_WHILE_WRITE_SECTION_START_WORD);

  // ----------------------------------------------------------------
  // store permission
  // ----------------------------------------------------------------
  // general lock modes are not inputs here, so they cannot gate stores
  assign program_req = program_store_instr_in && exec_in_boot;
  // a programmed low bit (field 10 or 00) refuses store writes; 01 only fences loads
  assign store_blocked = target_in_boot ? !boot_protect[0]
                                        : !app_protect[0];
  assign store_allowed = program_req && !store_blocked && state == ENG_IDLE;

  // ----------------------------------------------------------------
  // programming engine
  // ----------------------------------------------------------------
  // one operation at a time; section decides stall or read-while-write
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state <= ENG_IDLE;
    end
    else
    begin
      case (state)
        ENG_IDLE:
        begin
          if (store_allowed && (store_op_t'(store_op_in) == STORE_ERASE ||
                                store_op_t'(store_op_in) == STORE_WRITE))
          begin
            state <= target_in_no_read_while_write_section ? ENG_NO_READ_WHILE_WRITE_SECTION_BUSY : ENG_RWW_BUSY;
          end
        end
        ENG_RWW_BUSY, ENG_NO_READ_WHILE_WRITE_SECTION_BUSY:
        begin
          if (flash_done_in)
          begin
            state <= ENG_IDLE;
          end
        end
        default:
        begin
          state <= ENG_IDLE;
        end
      endcase
    end
  end

  // start pulses and latched page for the flash macro
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      flash_erase_start_out <= 1'b0;
      flash_write_start_out <= 1'b0;
      flash_page_out <= 9'h000;
    end
    else
    begin
      flash_erase_start_out <= store_allowed && store_op_t'(store_op_in) == STORE_ERASE;
      flash_write_start_out <= store_allowed && store_op_t'(store_op_in) == STORE_WRITE;
      if (store_allowed && (store_op_t'(store_op_in) == STORE_ERASE ||
                            store_op_t'(store_op_in) == STORE_WRITE))
      begin
        flash_page_out <= target_page;
      end
    end
  end

  // temporary buffer fill, word index from the low pointer bits
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      buffer_fill_out <= 1'b0;
      buffer_word_out <= 6'h00;
    end
    else
    begin
      buffer_fill_out <= program_req && state == ENG_IDLE &&
                         store_op_t'(store_op_in) == STORE_FILL;
      buffer_word_out <= target_word[PAGE_WORD_BITS-1:0];
    end
  end

  // ----------------------------------------------------------------
  // read-while-write busy flag
  // ----------------------------------------------------------------
  // set on start of rww programming, cleared by software after completion
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rww_busy <= 1'b0;
    end
    else if (store_allowed && !target_in_no_read_while_write_section && (store_op_t'(store_op_in) == STORE_ERASE ||
                                                  store_op_t'(store_op_in) == STORE_WRITE))
    begin
      rww_busy <= 1'b1;
    end
    else if (rww_reenable_in && state != ENG_RWW_BUSY)
    begin
      rww_busy <= 1'b0;
    end
  end

  assign rww_busy_flag_out = rww_busy;
  assign stall_core_out = (state == ENG_NO_READ_WHILE_WRITE_SECTION_BUSY);

  // ----------------------------------------------------------------
  // load and fetch access
  // ----------------------------------------------------------------
  // cross-section reads refused by the protection high bit being zero
  assign load_blocked = (exec_in_boot && !target_in_boot && !app_protect[1]) ||
                        (!exec_in_boot && target_in_boot && !boot_protect[1]) ||
                        (rww_busy && !target_in_no_read_while_write_section);

  assign flash_read_addr_out = target_word;
  assign fetch_blocked_out = fetch_req_in && rww_busy &&
                             (exec_word_addr_in < NO_READ_WHILE_WRITE_SECTION_START_WORD);

  // byte selected by pointer bit zero; refused reads give a fixed byte
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      load_valid_out <= 1'b0;
      load_data_out <= LOAD_DATA_RESET;
    end
    else
    begin
      load_valid_out <= load_req_in;
      if (load_req_in && load_blocked)
      begin
        load_data_out <= BLOCKED_READ_BYTE;
      end
      else if (load_req_in)
      begin
        load_data_out <= pointer[0] ? flash_read_data_in[15:8]
                                    : flash_read_data_in[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt masking and reset vector
  // ----------------------------------------------------------------
  // mask interrupts away from the vector section when the executing section is load-fenced
  assign next_irq_block = (!app_protect[1] && vectors_in_boot_in && !exec_in_boot) ||
                          (!boot_protect[1] && !vectors_in_boot_in && exec_in_boot);

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      irq_block_out <= 1'b0;
      reset_vector_out <= APP_RESET_WORD;
    end
    else
    begin
      irq_block_out <= next_irq_block;
      reset_vector_out <= boot_fuse_programmed ? BOOT_START_WORD : APP_RESET_WORD;
    end
  end

  assign app_protect_out = app_protect;
  assign boot_protect_out = boot_protect;

endmodule : boot_flash_access_guard

`default_nettype wire

// ==== verif/flash_macro_model.sv ====
// stand-in for the flash macro behind the guard
// assumes one-cycle start pulses on the guard's clock
`timescale 1ns/1ps
`default_nettype none

module flash_macro_model
#(
  parameter int BUSY_CYCLES = 12
)
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [14:0] read_addr_in,
  input wire logic start_in,
  output logic [15:0] read_data_out,
  output logic done_out
);
  int count;

  // address-derived word, so high and low bytes always differ
  assign read_data_out = {read_addr_in[7:0] ^ 8'h5a, read_addr_in[7:0]};

  // count out an erase or write, then pulse done once
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      count <= 0;
      done_out <= 1'b0;
    end
    else
    begin
      done_out <= (count == 1);
      if (start_in)
        count <= BUSY_CYCLES;
      else if (count > 0)
        count <= count - 1;
    end
  end
endmodule : flash_macro_model

`default_nettype wire

// ==== verif/boot_flash_access_guard_asserts.sv ====
// checker for the boot flash access guard
// assumes it is bound to the guard and sees its ports only
`timescale 1ns/1ps
`default_nettype none

module boot_guard_checker
  import boot_guard_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [14:0] exec_word_addr_in,
  input wire logic vectors_in_boot_in,
  input wire logic [7:0] pointer_high_byte_in,
  input wire logic [7:0] pointer_low_byte_in,
  input wire logic program_store_instr_in,
  input wire logic load_req_in,
  input wire logic boot_reset_select_fuse_in,
  input wire logic stall_core_out,
  input wire logic rww_busy_flag_out,
  input wire logic irq_block_out,
  input wire logic [14:0] reset_vector_out,
  input wire logic load_valid_out,
  input wire logic [7:0] load_data_out,
  input wire logic [1:0] app_protect_out,
  input wire logic [1:0] boot_protect_out,
  input wire logic flash_erase_start_out,
  input wire logic flash_write_start_out,
  input wire logic [8:0] flash_page_out,
  input wire logic [15:0] flash_read_data_in
);
  logic [2:0] since_reset;
  wire logic in_boot = exec_word_addr_in >= BOOT_START_WORD;
  wire logic ptr_boot = {pointer_high_byte_in, pointer_low_byte_in[7:1]} >= BOOT_START_WORD;
  wire logic start = flash_erase_start_out | flash_write_start_out;
  wire logic no_read_while_write_section_page = flash_page_out >= NO_READ_WHILE_WRITE_SECTION_START_WORD[14:6];
  wire logic open_fields = (app_protect_out == PROT_FIELD_ERASED) &&
    (boot_protect_out == PROT_FIELD_ERASED);

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  // cycles since reset release, saturating
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      since_reset <= 3'h0;
    else if (since_reset != 3'h7)
      since_reset <= since_reset + 3'h1;
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_app_store_ignored;
    program_store_instr_in && !in_boot |=> !start;
  endproperty
  a_app_store_ignored: assert property (p_app_store_ignored)
    else $error("store from application started programming");
  property p_store_refused;
    program_store_instr_in &&
      (ptr_boot ? !boot_protect_out[0] : !app_protect_out[0]) |=> !start;
  endproperty
  a_store_refused: assert property (p_store_refused)
    else $error("store into a write-protected section started programming");
  property p_page_from_pointer;
    start |-> flash_page_out == $past({pointer_high_byte_in, pointer_low_byte_in[7]});
  endproperty
  a_page_from_pointer: assert property (p_page_from_pointer)
    else $error("page number not taken from pointer");
  property p_page_held;
    !start |-> $stable(flash_page_out);
  endproperty
  a_page_held: assert property (p_page_held)
    else $error("page changed without a start");
  property p_no_read_while_write_section_stall;
    start && no_read_while_write_section_page |-> stall_core_out;
  endproperty
  a_no_read_while_write_section_stall: assert property (p_no_read_while_write_section_stall)
    else $error("core not stalled for no_read_while_write_section operation");
  property p_rww_free;
    start && !no_read_while_write_section_page |-> !stall_core_out && rww_busy_flag_out;
  endproperty
  a_rww_free: assert property (p_rww_free)
    else $error("rww operation stalled core or left busy low");
  property p_load_byte;
    load_req_in && !rww_busy_flag_out && open_fields |=> load_valid_out &&
      load_data_out == ($past(pointer_low_byte_in[0]) ?
      $past(flash_read_data_in[15:8]) : $past(flash_read_data_in[7:0]));
  endproperty
  a_load_byte: assert property (p_load_byte)
    else $error("load byte selection wrong");
  property p_cross_block;
    load_req_in && ((in_boot && !ptr_boot && !app_protect_out[1]) ||
      (!in_boot && ptr_boot && !boot_protect_out[1])) |=> load_data_out == BLOCKED_READ_BYTE;
  endproperty
  a_cross_block: assert property (p_cross_block)
    else $error("forbidden load returned data");
  property p_irq_block;
    (!in_boot && vectors_in_boot_in && !app_protect_out[1]) ||
      (in_boot && !vectors_in_boot_in && !boot_protect_out[1]) |=> irq_block_out;
  endproperty
  a_irq_block: assert property (p_irq_block)
    else $error("interrupts not masked");
  property p_vector_value;
    since_reset == 3'h5 |->
      reset_vector_out == (boot_reset_select_fuse_in ? APP_RESET_WORD : BOOT_START_WORD);
  endproperty
  a_vector_value: assert property (p_vector_value)
    else $error("reset vector does not follow fuse");
  property p_vector_held;
    since_reset == 3'h7 |-> $stable(reset_vector_out);
  endproperty
  a_vector_held: assert property (p_vector_held)
    else $error("reset vector changed while running");
endmodule : boot_guard_checker

bind boot_flash_access_guard boot_guard_checker checker_inst (.clock_in, .rst_in,
  .exec_word_addr_in, .vectors_in_boot_in, .pointer_high_byte_in, .pointer_low_byte_in,
  .program_store_instr_in, .load_req_in, .boot_reset_select_fuse_in, .stall_core_out,
  .rww_busy_flag_out, .irq_block_out, .reset_vector_out, .load_valid_out, .load_data_out,
  .app_protect_out, .boot_protect_out, .flash_erase_start_out, .flash_write_start_out,
  .flash_page_out, .flash_read_data_in);

`default_nettype wire

// ==== verif/boot_flash_access_guard_test.sv ====
// self-checking bench for the boot flash access guard
// assumes the flash macro model and the bound checker
`timescale 1ns/1ps
`default_nettype none

module boot_flash_access_guard_test
  import boot_guard_pkg::*;
;
  logic clock_in, rst_in, app_hi, app_lo, boot_hi, boot_lo, fuse, chip_erase, vec_boot;
  logic store, load, fetch, reenable, stall, busy, irq_block, load_valid, fetch_blocked;
  logic erase_go, write_go, fill, done;
  logic [14:0] exec_addr, rvec, rd_addr;
  logic [15:0] ptr, rd_data;
  logic [1:0] op, app_prot, boot_prot;
  logic [7:0] lock_data, load_data;
  logic [8:0] page;
  logic [5:0] word;
  int fail_count, samples_checked;

  boot_flash_access_guard uut (.clock_in(clock_in), .rst_in(rst_in),
    .app_protect_bit_hi_in(app_hi), .app_protect_bit_lo_in(app_lo),
    .boot_protect_bit_hi_in(boot_hi), .boot_protect_bit_lo_in(boot_lo),
    .boot_reset_select_fuse_in(fuse), .chip_erase_in(chip_erase),
    .exec_word_addr_in(exec_addr), .vectors_in_boot_in(vec_boot),
    .pointer_high_byte_in(ptr[15:8]), .pointer_low_byte_in(ptr[7:0]),
    .program_store_instr_in(store), .store_op_in(op), .lock_data_in(lock_data),
    .load_req_in(load), .fetch_req_in(fetch), .rww_reenable_in(reenable),
    .stall_core_out(stall), .rww_busy_flag_out(busy), .irq_block_out(irq_block),
    .reset_vector_out(rvec), .load_valid_out(load_valid), .load_data_out(load_data),
    .fetch_blocked_out(fetch_blocked), .app_protect_out(app_prot),
    .boot_protect_out(boot_prot), .flash_read_addr_out(rd_addr),
    .flash_read_data_in(rd_data), .flash_erase_start_out(erase_go),
    .flash_write_start_out(write_go), .flash_page_out(page), .buffer_fill_out(fill),
    .buffer_word_out(word), .flash_done_in(done));

  flash_macro_model flash (.clock_in(clock_in), .rst_in(rst_in), .read_addr_in(rd_addr),
    .start_in(erase_go | write_go), .read_data_out(rd_data), .done_out(done));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // one-cycle store or load request, returns in the answer cycle
  task automatic req(input logic ld, input logic [1:0] kind, input logic [15:0] where,
    input logic [14:0] from, input logic [7:0] lock);
    @(posedge clock_in);
    store <= !ld;
    load <= ld;
    op <= kind;
    ptr <= where;
    exec_addr <= from;
    lock_data <= lock;
    @(posedge clock_in);
    store <= 1'b0;
    load <= 1'b0;
    #1;
  endtask : req

  task automatic wait_done();
    int n;
    n = 0;
    do
    begin
      @(posedge clock_in);
      n++;
    end while (done !== 1'b1 && n < 100);
    if (n >= 100)
      fail_count++;
    #1;
  endtask : wait_done

  task automatic do_reset();
    rst_in <= 1'b1;
    repeat (8) @(posedge clock_in);
    rst_in <= 1'b0;
    repeat (5) @(posedge clock_in);
    #1;
  endtask : do_reset

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  // free-running 100 MHz clock
  initial
  begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  // watchdog against a hung handshake
  initial
  begin
    #100_000;
    fail_count++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    {rst_in, app_hi, app_lo, boot_hi, boot_lo, fuse} = 6'h3f;
    {chip_erase, vec_boot, store, load, fetch, reenable} = 6'h00;
    exec_addr = 15'h0000;
    ptr = 16'h0000;
    op = STORE_FILL;
    lock_data = 8'hff;
    fail_count = 0;
    samples_checked = 0;
    do_reset();
    check(rvec, APP_RESET_WORD);
    check({app_prot, boot_prot}, 16'h000f);
    for (int i = 0; i < 2; i++)
    begin
      req(1'b1, STORE_FILL, 16'h1234 + 16'(i), 15'h0100, 8'hff);
      check({load_valid, load_data}, {8'h01, i ? 8'h40 : 8'h1a});
    end
    req(1'b0, STORE_ERASE, 16'h0200, 15'h0100, 8'hff);
    check(erase_go, 1'b0);
    req(1'b0, STORE_ERASE, 16'h0200, 15'h3800, 8'hff);
    check({erase_go, page}, 16'h0204);
    check({stall, busy}, 16'h0001);
    @(posedge clock_in);
    fetch <= 1'b1;
    exec_addr <= 15'h3900;
    #1;
    check(fetch_blocked, 1'b0);
    @(posedge clock_in);
    exec_addr <= 15'h0010;
    #1;
    check(fetch_blocked, 1'b1);
    req(1'b1, STORE_FILL, 16'h0040, 15'h3800, 8'hff);
    check(load_data, BLOCKED_READ_BYTE);
    wait_done();
    check(busy, 1'b1);
    @(posedge clock_in);
    fetch <= 1'b0;
    reenable <= 1'b1;
    @(posedge clock_in);
    reenable <= 1'b0;
    #1;
    check(busy, 1'b0);
    req(1'b0, STORE_ERASE, 16'h7400, 15'h3800, 8'hff);
    wait_done();
    req(1'b0, STORE_WRITE, 16'h7400, 15'h3800, 8'hff);
    check({write_go, stall, page}, 16'h06e8);
    wait_done();
    check(stall, 1'b0);
    req(1'b0, STORE_FILL, 16'h004a, 15'h3800, 8'hff);
    check({fill, word}, 16'h0065);
    req(1'b0, STORE_LOCK_SET, 16'hffff, 15'h3800, 8'hfb);
    repeat (2) @(posedge clock_in);
    check({app_prot, boot_prot}, 16'h000b);
    req(1'b0, STORE_ERASE, 16'h0200, 15'h3800, 8'hff);
    check(erase_go, 1'b0);
    req(1'b0, STORE_LOCK_SET, 16'h0001, 15'h3800, 8'hdf);
    repeat (2) @(posedge clock_in);
    check(boot_prot, 2'h1);
    req(1'b0, STORE_ERASE, 16'h7400, 15'h3800, 8'hff);
    check({erase_go, stall, page}, 16'h06e8);
    wait_done();
    req(1'b1, STORE_FILL, 16'h7101, 15'h0100, 8'hff);
    check(load_data, BLOCKED_READ_BYTE);
    req(1'b1, STORE_FILL, 16'h0000, 15'h3900, 8'hff);
    @(posedge clock_in);
    #1;
    check(irq_block, 1'b1);
    @(posedge clock_in);
    chip_erase <= 1'b1;
    repeat (6) @(posedge clock_in);
    #1;
    check({app_prot, boot_prot}, 16'h000f);
    @(posedge clock_in);
    chip_erase <= 1'b0;
    fuse <= 1'b0;
    app_hi <= 1'b0;
    do_reset();
    check(rvec, BOOT_START_WORD);
    check(app_prot, 2'h1);
    req(1'b1, STORE_FILL, 16'h0100, 15'h3800, 8'hff);
    check(load_data, BLOCKED_READ_BYTE);
    @(posedge clock_in);
    vec_boot <= 1'b1;
    req(1'b1, STORE_FILL, 16'h0100, 15'h0100, 8'hff);
    @(posedge clock_in);
    #1;
    check(irq_block, 1'b1);
    complete_run();
  end
endmodule : boot_flash_access_guard_test

`default_nettype wire
